// file: peripheral_pin_partner.sv
// model of the peripherals and pads around the pin router
`timescale 1ns/1ps
`default_nettype none

module peripheral_pin_partner (
    input wire logic ref_clk,  // system clock
    input wire logic load,  // take a new pattern
    input wire logic [31:0] seed,  // pattern source
    output logic [31:0] srcOut,  // peripheral outputs by code
    output logic [31:0] srcDirOvr,  // peripheral owns direction
    output logic [31:0] srcDirIn,  // wanted direction, 1 = input
    output logic [39:0] pinIn,  // external pin levels
    output logic [39:0] pinLatch,  // port latch values
    output logic [39:0] pinDirCtrl  // port direction, 1 = input
);
    // only the bidirectional sources ever claim the pin direction
    localparam logic [31:0] OWNS_DIR = 32'h0033_0f00;

    // quiet start so nothing floats before the first pattern
    initial begin
        {srcOut, srcDirOvr, srcDirIn} = '0;
        {pinIn, pinLatch, pinDirCtrl} = '0;
    end

    // a pattern changes every field at once, code 0 carries no source
    always @(posedge ref_clk) begin
        if (load) begin
            srcOut <= {seed[30:0], 1'b0};
            srcDirOvr <= OWNS_DIR & ~{seed[15:0], seed[31:16]};
            srcDirIn <= {seed[7:0], seed[31:8]};
            pinIn <= {seed[7:0], seed ^ 32'h5a5a_a5a5};
            pinLatch <= {seed[31:24], ~seed};
            pinDirCtrl <= {seed[11:4], seed[27:0], seed[31:28]};
        end
    end
endmodule : peripheral_pin_partner

`default_nettype wire

// file: peripheral_pin_router.sv
// pin router: peripheral input selection, pin output selection, lock
`timescale 1ns/1ps
`default_nettype none

module peripheral_pin_router #(
    parameter bit LARGE_VARIANT = 1'b1  // 1: ports d and e present
) (
    input wire logic ref_clk,  // system clock, 25 MHz
    input wire logic rstn,  // any reset, async, active low
    input wire logic porRstn,  // power-on/brown-out reset, active low
    input wire peripheral_pin_router_pkg::reg_req_s regReq,  // register port
    output logic [7:0] regRdata,  // read data, cycle after read strobe
    input wire logic oneShotLockConfig,  // one-way lock configuration bit
    input wire logic [39:0] pinIn,  // pin levels, ports a..e
    input wire logic [39:0] pinLatch,  // per-pin output latch values
    input wire logic [39:0] pinDirCtrl,  // per-pin direction, 1 = input
    input wire logic [31:0] srcOut,  // peripheral outputs by code
    input wire logic [31:0] srcDirOvr,  // peripheral owns pin direction
    input wire logic [31:0] srcDirIn,  // peripheral direction, 1 = input
    output logic [15:0] periphIn,  // routed peripheral inputs
    output logic [39:0] pinOut,  // pin output values
    output logic [39:0] pinOe,  // pin output enables, high = drive
    output logic routingLocked  // lock flag
);

    // ********************************
    // decode functions
    // ********************************

    // supported input ports per selector, bit0 = a .. bit3 = d
    function automatic logic [3:0] inPortMask(input logic [3:0] idx,
                                              input logic wide);
        logic [3:0] maskSmall;
        logic [3:0] maskBig;
        maskSmall = 4'h0;
        maskBig = 4'h0;
        case (idx)
            4'h0, 4'h1: begin  // ext int, timer0 clock: a, b
                maskSmall = 4'h3;
                maskBig = 4'h3;
            end
            4'h2, 4'hc, 4'hd: begin  // timer1 clock, logic in0/1: a, c
                maskSmall = 4'h5;
                maskBig = 4'h5;
            end
            4'h6, 4'he, 4'hf: begin  // complementary, logic in2/3
                maskSmall = 4'h6;
                maskBig = 4'ha;
            end
            4'h9: begin  // serial select: a, c or d
                maskSmall = 4'h5;
                maskBig = 4'h9;
            end
            default: begin  // gate, captures, serial, uart: b, c
                maskSmall = 4'h6;
                maskBig = 4'h6;
            end
        endcase
        return wide ? maskBig : maskSmall;
    endfunction : inPortMask

    // supported ports per output code, bit0 = a .. bit4 = e
    function automatic logic [4:0] outPortMask(input logic [4:0] code,
                                               input logic wide);
        logic [4:0] maskSmall;
        logic [4:0] maskBig;
        maskSmall = 5'h00;
        maskBig = 5'h00;
        case (code)
            5'h00: begin  // latch goes everywhere
                maskSmall = 5'h07;
                maskBig = 5'h1f;
            end
            5'h03, 5'h16: begin  // oscillator, comparator 1
                maskSmall = 5'h05;
                maskBig = 5'h09;
            end
            5'h04, 5'h05: begin  // logic cells 1, 2
                maskSmall = 5'h05;
                maskBig = 5'h05;
            end
            5'h06, 5'h07, 5'h09, 5'h0a, 5'h0b, 5'h0f: begin
                maskSmall = 5'h06;
                maskBig = 5'h0a;
            end
            5'h08, 5'h0c, 5'h0d, 5'h10, 5'h11, 5'h14, 5'h15: begin
                maskSmall = 5'h06;
                maskBig = 5'h06;
            end
            5'h0e: begin  // pwm 3
                maskSmall = 5'h06;
                maskBig = 5'h12;
            end
            5'h17: begin  // comparator 2
                maskSmall = 5'h05;
                maskBig = 5'h11;
            end
            default: begin  // reserved codes route nothing
                maskSmall = 5'h00;
                maskBig = 5'h00;
            end
        endcase
        return wide ? maskBig : maskSmall;
    endfunction : outPortMask

    // pins that own an output selector
    function automatic logic pinImpl(input logic [5:0] pin,
                                     input logic wide);
        logic ok;
        ok = 1'b0;
        case (pin[5:3])
            3'h0: ok = (pin[2:0] != 3'h3);
            3'h1, 3'h2: ok = 1'b1;
            3'h3: ok = wide;
            3'h4: ok = wide && (pin[2:0] < 3'h3);
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction : pinImpl

    // sources that steer the pin driver themselves
    function automatic logic ownsDir(input logic [4:0] code);
        return ((code >= peripheral_pin_router_pkg::SRC_COMP_A) &&
                (code <= peripheral_pin_router_pkg::SRC_COMP_D)) ||
               (code == peripheral_pin_router_pkg::SRC_SER_CLK) ||
               (code == peripheral_pin_router_pkg::SRC_SER_DOUT) ||
               (code == peripheral_pin_router_pkg::SRC_UART_TXCK) ||
               (code == peripheral_pin_router_pkg::SRC_UART_DT);
    endfunction : ownsDir

    // ********************************
    // state
    // ********************************
    logic [15:0][4:0] inSel;
    logic [39:0][4:0] outSel;
    logic [39:0] pinMeta;
    logic [39:0] pinSync;
    logic cfgMeta;
    logic oneWay;
    logic clearedOnce;
    logic setOnce;
    peripheral_pin_router_pkg::unlock_e seqState;
    peripheral_pin_router_pkg::unlock_e next_seqState;

    // ********************************
    // register decode
    // ********************************
    wire logic [7:0] outOffset = regReq.addr -
                                 peripheral_pin_router_pkg::ADDR_OUT_BASE;
    wire logic [5:0] outIdx = outOffset[5:0];
    wire logic [3:0] inIdx = regReq.addr[3:0];
    wire logic lockHit = regReq.addr == peripheral_pin_router_pkg::ADDR_LOCK;
    wire logic inHit = regReq.addr[7:4] ==
                       peripheral_pin_router_pkg::ADDR_IN_BASE[7:4];
    wire logic outHit = (regReq.addr >=
                         peripheral_pin_router_pkg::ADDR_OUT_BASE) &&
                        (regReq.addr <
                         peripheral_pin_router_pkg::ADDR_OUT_END) &&
                        pinImpl(outIdx, LARGE_VARIANT);
    wire logic inWr = regReq.wr && inHit && !routingLocked;
    wire logic outWr = regReq.wr && outHit && !routingLocked;
    wire logic lockWr = regReq.wr && lockHit;
    wire logic newFlag = regReq.wdata[peripheral_pin_router_pkg::LOCK_BIT];
    // one-way: a clear only before any set, a set only once
    wire logic flagAllowed = !oneWay ||
                             (newFlag ? !setOnce
                                      : (!clearedOnce && !setOnce));
    wire logic flagTake = lockWr && (seqState ==
                          peripheral_pin_router_pkg::SEQ_ARMED) &&
                          flagAllowed;
    wire logic [7:0] rdNext = lockHit ? {7'h00, routingLocked} :
                              inHit ? {3'h0, inSel[inIdx]} :
                              outHit ? {3'h0, outSel[outIdx]} :
                              8'h00;

    // ********************************
    // unlock sequence
    // ********************************

    // any other write between the keys and the flag write breaks the
    // sequence, so a stray store cannot unlock the routing
    always_comb begin
        next_seqState = seqState;
        if (regReq.wr) begin
            if (lockWr && regReq.wdata ==
                peripheral_pin_router_pkg::UNLOCK_KEY1 &&
                seqState != peripheral_pin_router_pkg::SEQ_ARMED) begin
                next_seqState = peripheral_pin_router_pkg::SEQ_GOT_KEY1;
            end else if (lockWr && regReq.wdata ==
                         peripheral_pin_router_pkg::UNLOCK_KEY2 &&
                         seqState ==
                         peripheral_pin_router_pkg::SEQ_GOT_KEY1) begin
                next_seqState = peripheral_pin_router_pkg::SEQ_ARMED;
            end else begin
                next_seqState = peripheral_pin_router_pkg::SEQ_IDLE;
            end
        end
    end

    // lock state clears on every reset
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            seqState <= peripheral_pin_router_pkg::SEQ_IDLE;
            routingLocked <= peripheral_pin_router_pkg::LOCK_RST;
            clearedOnce <= 1'b0;
            setOnce <= 1'b0;
        end else begin
            seqState <= next_seqState;
            if (flagTake) begin
                routingLocked <= newFlag;
                setOnce <= setOnce | newFlag;
                clearedOnce <= clearedOnce | !newFlag;
            end
        end
    end

    // configuration bit and pins come from outside the clock domain
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            cfgMeta <= 1'b0;
            oneWay <= 1'b0;
            pinMeta <= 40'h0;
            pinSync <= 40'h0;
        end else begin
            cfgMeta <= oneShotLockConfig;
            oneWay <= cfgMeta;
            pinMeta <= pinIn;
            pinSync <= pinMeta;
        end
    end

    // ********************************
    // selector registers
    // ********************************

    // selections survive every reset but power-on
    always_ff @(posedge ref_clk or negedge porRstn) begin
        if (!porRstn) begin
            inSel <= peripheral_pin_router_pkg::IN_SEL_RST;
        end else if (inWr) begin
            inSel[inIdx] <= regReq.wdata[4:0];
        end
    end

    // output selectors default to the pin latch
    always_ff @(posedge ref_clk or negedge porRstn) begin
        if (!porRstn) begin
            outSel <= {40{peripheral_pin_router_pkg::OUT_SEL_RST}};
        end else if (outWr) begin
            outSel[outIdx] <= regReq.wdata[4:0];
        end
    end

    // read data stand one cycle only, zero otherwise
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            regRdata <= 8'h00;
        end else begin
            regRdata <= regReq.rd ? rdNext : 8'h00;
        end
    end

    // ********************************
    // input routing
    // ********************************
    logic [15:0] inOk;
    logic [15:0][4:0] inPin;
    logic [15:0] next_periphIn;

    for (genvar g = 0; g < 16; g++) begin : g_in
        wire logic [1:0] port = inSel[g][4:3];
        wire logic [3:0] mask = inPortMask(4'(g), LARGE_VARIANT);
        assign inOk[g] = mask[port];
        assign inPin[g] = {port, inSel[g][2:0]};
        // an unsupported port reads as zero, not as a stray pin
        assign next_periphIn[g] = inOk[g] && pinSync[inPin[g]];
    end

    // registered to keep the peripheral inputs glitch free
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            periphIn <= 16'h0;
        end else begin
            periphIn <= next_periphIn;
        end
    end

    // ********************************
    // output routing
    // ********************************
    logic [39:0] outOk;
    logic [39:0] outOvr;
    logic [39:0] next_pinOut;
    logic [39:0] next_pinOe;

    for (genvar p = 0; p < 40; p++) begin : g_out
        wire logic [4:0] code = outSel[p];
        wire logic [4:0] mask = outPortMask(code, LARGE_VARIANT);
        wire logic impl = pinImpl(6'(p), LARGE_VARIANT);
        assign outOk[p] = impl && mask[p / 8];
        assign next_pinOut[p] = !outOk[p] ? 1'b0 :
                                (code == peripheral_pin_router_pkg::SRC_LATCH)
                                ? pinLatch[p] : srcOut[code];
        assign outOvr[p] = outOk[p] && ownsDir(code) && srcDirOvr[code];
        // pins without a selector stay under plain direction control
        assign next_pinOe[p] = outOvr[p] ? !srcDirIn[code]
                                         : !pinDirCtrl[p];
    end

    // pin drivers come from flip-flops
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            pinOut <= 40'h0;
            pinOe <= 40'h0;
        end else begin
            pinOut <= next_pinOut;
            pinOe <= next_pinOe;
        end
    end

    // ********************************
    // assertions
    // ********************************
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstn || !porRstn);

    AST_RD_PAD: assert property (
        regReq.rd && outHit |=> regRdata[7:5] == 3'h0 &&
            regRdata[4:0] == $past(outSel[outIdx]))
        else $error("output selector read wrong");
    AST_LOCK_RD: assert property (
        regReq.rd && lockHit |=> regRdata == {7'h00, routingLocked})
        else $error("lock register read wrong");
    AST_FROZEN: assert property (
        routingLocked && regReq.wr |=> $stable(inSel) && $stable(outSel))
        else $error("selector changed while locked");
    AST_SEQ: assert property (
        !$stable(routingLocked) |->
            $past(seqState) == peripheral_pin_router_pkg::SEQ_ARMED &&
            $past(lockWr))
        else $error("lock flag changed without key sequence");
    AST_ONE_WAY: assert property (
        oneWay && setOnce && routingLocked |=> routingLocked)
        else $error("one-way lock cleared");

    for (genvar g = 0; g < 16; g++) begin : g_in_chk
        AST_IN_ZERO: assert property (
            !inOk[g] |=> !periphIn[g])
            else $error("unsupported input port not zero");
        AST_IN_ROUTE: assert property (
            inOk[g] |=> periphIn[g] == $past(pinSync[inPin[g]]))
            else $error("input not routed from selected pin");
    end

    for (genvar p = 0; p < 40; p++) begin : g_out_chk
        AST_OUT_ZERO: assert property (
            !outOk[p] |=> !pinOut[p])
            else $error("reserved or unsupported output not zero");
        AST_OUT_LATCH: assert property (
            outOk[p] && outSel[p] == peripheral_pin_router_pkg::SRC_LATCH
            |=> pinOut[p] == $past(pinLatch[p]))
            else $error("latch not routed to pin");
        AST_DIR_OVR: assert property (
            outOvr[p] |=> pinOe[p] == !$past(srcDirIn[outSel[p]]))
            else $error("peripheral direction override missing");
    end

    COV_UNLOCK: cover property (
        seqState == peripheral_pin_router_pkg::SEQ_ARMED && flagTake &&
        !newFlag);
    COV_LOCK: cover property (!routingLocked ##1 routingLocked);
    COV_BLOCKED: cover property (routingLocked && inHit && regReq.wr);
    COV_ROUTE: cover property (inOk[10] && next_periphIn[10]);

endmodule : peripheral_pin_router

`default_nettype wire

// file: peripheral_pin_router_pkg.sv
// constants, types and reset values shared by the pin router
package peripheral_pin_router_pkg;

    // ********************************
    // sizes
    // ********************************
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int SEL_W = 5;
    localparam int NUM_IN = 16;
    localparam int NUM_PINS = 40;
    localparam int NUM_SRC = 32;

    // ********************************
    // register map (byte offsets on the plain register port)
    // ********************************
    localparam logic [7:0] ADDR_LOCK = 8'h00;
    localparam logic [7:0] ADDR_IN_BASE = 8'h10;
    localparam logic [7:0] ADDR_OUT_BASE = 8'h20;
    localparam logic [7:0] ADDR_OUT_END = 8'h48;

    // ********************************
    // fields
    // ********************************
    localparam int LOCK_BIT = 0;
    localparam int SEL_PORT_MSB = 4;
    localparam int SEL_PORT_LSB = 3;
    localparam int SEL_BIT_MSB = 2;

    // ********************************
    // keys and reset values
    // ********************************
    localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
    localparam logic [7:0] UNLOCK_KEY2 = 8'haa;
    localparam logic [4:0] OUT_SEL_RST = 5'h00;
    localparam logic LOCK_RST = 1'h0;
    // input selector defaults, index 15 (logic in3) down to 0 (ext int)
    localparam logic [NUM_IN-1:0][SEL_W-1:0] IN_SEL_RST = {
        5'h09, 5'h08, 5'h01, 5'h00, 5'h16, 5'h17, 5'h05, 5'h14,
        5'h13, 5'h08, 5'h11, 5'h12, 5'h0d, 5'h10, 5'h04, 5'h00};

    // ********************************
    // output source codes
    // ********************************
    localparam logic [4:0] SRC_LATCH = 5'h00;
    localparam logic [4:0] SRC_COMP_A = 5'h08;
    localparam logic [4:0] SRC_COMP_D = 5'h0b;
    localparam logic [4:0] SRC_SER_CLK = 5'h10;
    localparam logic [4:0] SRC_SER_DOUT = 5'h11;
    localparam logic [4:0] SRC_UART_TXCK = 5'h14;
    localparam logic [4:0] SRC_UART_DT = 5'h15;

    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_GOT_KEY1 = 2'b01,
        SEQ_ARMED = 2'b10
    } unlock_e;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } reg_req_s;

endpackage : peripheral_pin_router_pkg

// file: test_peripheral_pin_router.sv
// self-checking bench for the pin router
`timescale 1ns/1ps
`default_nettype none

module test_peripheral_pin_router;
    // ********************************
    // port support tables, bit 0 is port a
    // ********************************
    localparam logic [31:0][4:0] OUT_OK = {
        5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00,
        5'h11, 5'h09, 5'h06, 5'h06, 5'h00, 5'h00, 5'h06, 5'h06,
        5'h0a, 5'h12, 5'h06, 5'h06, 5'h0a, 5'h0a, 5'h0a, 5'h06,
        5'h0a, 5'h0a, 5'h05, 5'h05, 5'h09, 5'h00, 5'h00, 5'h1f};
    localparam logic [15:0][3:0] IN_OK = {
        4'ha, 4'ha, 4'h5, 4'h5, 4'h6, 4'h6, 4'h9, 4'h6,
        4'h6, 4'ha, 4'h6, 4'h6, 4'h6, 4'h5, 4'h3, 4'h3};
    // a3 and e3..e7 have no pad, so they are left out of compares
    localparam logic [39:0] MAPPED = 40'h07_ffff_fff7;

    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic porRstn = 1'b0;
    peripheral_pin_router_pkg::reg_req_s regReq = '0;
    logic oneShotLockConfig = 1'b0;
    logic load = 1'b0;
    logic [31:0] seed = 32'h6f71;
    logic [7:0] regRdata;
    logic [31:0] srcOut, srcDirOvr, srcDirIn;
    logic [39:0] pinIn, pinLatch, pinDirCtrl, pinOut, pinOe;
    logic [15:0] periphIn;
    logic routingLocked;
    logic [4:0] outSel [40];
    logic [4:0] inSel [16];
    int nMismatch = 0;
    int numChecks = 0;
    int cycles = 0;

    peripheral_pin_router u_peripheral_pin_router (
        .ref_clk(ref_clk), .rstn(rstn), .porRstn(porRstn),
        .regReq(regReq), .regRdata(regRdata),
        .oneShotLockConfig(oneShotLockConfig), .pinIn(pinIn),
        .pinLatch(pinLatch), .pinDirCtrl(pinDirCtrl),
        .srcOut(srcOut), .srcDirOvr(srcDirOvr), .srcDirIn(srcDirIn),
        .periphIn(periphIn), .pinOut(pinOut), .pinOe(pinOe),
        .routingLocked(routingLocked));

    peripheral_pin_partner u_peripheral_pin_partner (
        .ref_clk(ref_clk), .load(load), .seed(seed),
        .srcOut(srcOut), .srcDirOvr(srcDirOvr), .srcDirIn(srcDirIn),
        .pinIn(pinIn), .pinLatch(pinLatch), .pinDirCtrl(pinDirCtrl));

    // ********************************
    // helpers
    // ********************************
    initial begin
        forever #20 ref_clk = ~ref_clk;
    end

    // a hang costs a mismatch; a full run needs well under 10000 cycles
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            nMismatch++;
            end_of_test();
        end
    end

    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xorshift

    // expected {value, enable} of one pin
    function automatic logic [1:0] exp_pin(input int p, input logic [4:0] c);
        if (c == 5'h00) return {pinLatch[p], ~pinDirCtrl[p]};
        if (!OUT_OK[c][p / 8]) return {1'b0, ~pinDirCtrl[p]};
        if (srcDirOvr[c]) return {srcOut[c], ~srcDirIn[c]};
        return {srcOut[c], ~pinDirCtrl[p]};
    endfunction : exp_pin

    // selector value is port*8+bit, which is the pin index itself
    function automatic logic exp_in(input int i, input logic [4:0] s);
        if (!IN_OK[i][s[4:3]]) return 1'b0;
        return pinIn[s];
    endfunction : exp_in

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", numChecks, nMismatch);
        if (nMismatch == 0 && numChecks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_of_test

    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        numChecks++;
        if (got !== exp) begin
            nMismatch++;
            $display("mismatch %0t read %h exp %h", $time, got, exp);
        end
    endtask : chk_reg

    task automatic chk_vec(input logic [39:0] got, input logic [39:0] exp);
        numChecks++;
        if (got !== exp) begin
            nMismatch++;
            $display("mismatch %0t port %h exp %h", $time, got, exp);
        end
    endtask : chk_vec

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        regReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        regReq <= '0;
    endtask : wr

    // data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        regReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
        regReq <= '0;
        #1;
        d = regRdata;
    endtask : rd

    task automatic lock_seq(input logic [7:0] v);
        wr(peripheral_pin_router_pkg::ADDR_LOCK, 8'h55);
        wr(peripheral_pin_router_pkg::ADDR_LOCK, 8'haa);
        wr(peripheral_pin_router_pkg::ADDR_LOCK, v);
    endtask : lock_seq

    task automatic pulse_reset(input logic por);
        @(posedge ref_clk);
        rstn <= 1'b0;
        porRstn <= ~por;
        repeat (3) @(posedge ref_clk);
        rstn <= 1'b1;
        porRstn <= 1'b1;
    endtask : pulse_reset

    task automatic init_shadow();
        for (int i = 0; i < 16; i++) begin
            inSel[i] = peripheral_pin_router_pkg::IN_SEL_RST[i];
        end
        for (int p = 0; p < 40; p++) begin
            outSel[p] = 5'h00;
        end
    endtask : init_shadow

    // random codes with junk in bits 7-5; keep means writes must bounce
    task automatic write_all(input logic keep);
        for (int i = 0; i < 56; i++) begin
            seed = xorshift(seed);
            if (i < 16) begin
                wr(8'h10 + 8'(i), seed[7:0]);
                if (!keep) inSel[i] = seed[4:0];
            end else if (MAPPED[i - 16]) begin
                wr(8'h20 + 8'(i - 16), seed[7:0]);
                if (!keep) outSel[i - 16] = seed[4:0];
            end
        end
    endtask : write_all

    task automatic check_regs(input logic lockExp);
        logic [7:0] d;
        rd(peripheral_pin_router_pkg::ADDR_LOCK, d);
        chk_reg(d, {7'h00, lockExp});
        chk_vec({39'h0, routingLocked}, {39'h0, lockExp});
        for (int i = 0; i < 56; i++) begin
            rd(8'h10 + 8'(i), d);
            if (i < 16) chk_reg(d, {3'h0, inSel[i]});
            else if (!MAPPED[i - 16]) chk_reg(d, 8'h00);
            else chk_reg(d, {3'h0, outSel[i - 16]});
        end
    endtask : check_regs

    // new pattern, then wait out two sync stages and the routing stage
    task automatic check_route();
        logic [39:0] eOut, eOe;
        logic [15:0] eIn;
        seed = xorshift(seed);
        @(posedge ref_clk);
        load <= 1'b1;
        @(posedge ref_clk);
        load <= 1'b0;
        repeat (5) @(posedge ref_clk);
        #1;
        for (int p = 0; p < 40; p++) {eOut[p], eOe[p]} = exp_pin(p, outSel[p]);
        for (int i = 0; i < 16; i++) eIn[i] = exp_in(i, inSel[i]);
        chk_vec(pinOut & MAPPED, eOut & MAPPED);
        chk_vec(pinOe & MAPPED, eOe & MAPPED);
        chk_vec({24'h0, periphIn}, {24'h0, eIn});
    endtask : check_route

    // ********************************
    // main sequence
    // ********************************
    initial begin
        init_shadow();
        repeat (3) @(posedge ref_clk);
        rstn <= 1'b1;
        porRstn <= 1'b1;
        wr(8'h23, 8'h1f);
        check_regs(1'b0);
        check_route();
        for (int k = 0; k < 6; k++) begin
            write_all(1'b0);
            check_route();
            check_route();
            check_regs(1'b0);
        end
        wr(peripheral_pin_router_pkg::ADDR_LOCK, 8'h01);
        check_regs(1'b0);
        lock_seq(8'h01);
        write_all(1'b1);
        check_regs(1'b1);
        check_route();
        // a foreign write between the keys cancels the sequence
        wr(peripheral_pin_router_pkg::ADDR_LOCK, 8'h55);
        wr(8'h30, 8'h00);
        wr(peripheral_pin_router_pkg::ADDR_LOCK, 8'haa);
        wr(peripheral_pin_router_pkg::ADDR_LOCK, 8'h00);
        check_regs(1'b1);
        lock_seq(8'h00);
        check_regs(1'b0);
        lock_seq(8'h01);
        pulse_reset(1'b0);
        check_regs(1'b0);
        @(posedge ref_clk);
        oneShotLockConfig <= 1'b1;
        lock_seq(8'h00);
        check_regs(1'b0);
        lock_seq(8'h01);
        check_regs(1'b1);
        lock_seq(8'h00);
        check_regs(1'b1);
        write_all(1'b1);
        check_route();
        @(posedge ref_clk);
        oneShotLockConfig <= 1'b0;
        pulse_reset(1'b1);
        init_shadow();
        check_regs(1'b0);
        check_route();
        end_of_test();
    end
endmodule : test_peripheral_pin_router

`default_nettype wire
